// *** hdl/cdms_clk_gate.v ***
module cdms_clk_gate #(
    parameter N = 1
) (
    input  wire         mclk,
    input  wire         rst_b,
    input  wire         tick,
    input  wire [N-1:0] stopReq,
    output reg  [N-1:0] stopped_r,
    output reg  [N-1:0] clkEn_r
);

    // Stop requests take effect only on a domain tick
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            stopped_r <= {N{1'b1}};
            clkEn_r   <= {N{1'b0}};
        end else if (tick) begin
            stopped_r <= stopReq;
            clkEn_r   <= ~stopReq;
        end else begin
            clkEn_r   <= {N{1'b0}};
        end
    end

endmodule // cdms_clk_gate

// *** hdl/cdms_defs.vh ***
`ifndef CDMS_DEFS_VH
`define CDMS_DEFS_VH

// Register indices; byte address is four times the index
`define CDMS_IDX_RATIO      24'hfffdc4
`define CDMS_IDX_STOPA      24'hfffdc8
`define CDMS_IDX_STOPB      24'hfffdca
`define CDMS_IDX_STOPC      24'hfffdcc
`define CDMS_IDX_STATUS     24'hfffdce

// Ratio control field positions
`define CDMS_CORE_MSB       10
`define CDMS_CORE_LSB       8
`define CDMS_PERI_MSB       6
`define CDMS_PERI_LSB       4
`define CDMS_XBUS_MSB       2
`define CDMS_XBUS_LSB       0

// Ratio codes
`define CDMS_CODE_X8        3'h0
`define CDMS_CODE_X4        3'h1
`define CDMS_CODE_X2        3'h2
`define CDMS_CODE_X1        3'h3

// Stop register A fields
`define CDMS_A_ALLSTOP_EN   15
`define CDMS_A_DMA          13
`define CDMS_A_XFER         12
`define CDMS_A_CONV1        4
`define CDMS_A_CONV0        3
`define CDMS_A_TMR_HI       1
`define CDMS_A_TMR_LO       0
// Stop register B fields
`define CDMS_B_PULSE_GEN    15
`define CDMS_B_SERIAL4      12
`define CDMS_B_SERIAL3      11
// Stop register C fields
`define CDMS_C_SYNC2        10
`define CDMS_C_SYNC1        9
`define CDMS_C_SYNC0        8
`define CDMS_C_RAM_HI       1
`define CDMS_C_RAM_LO       0

// Writable masks (undescribed bits read zero)
`define CDMS_MASK_RATIO     16'h0777
`define CDMS_MASK_STOPA     16'hb01b
`define CDMS_MASK_STOPB     16'h9800
`define CDMS_MASK_STOPC     16'h0703
// Stop-bit-only masks for the all-stopped check
`define CDMS_STOPS_A        16'h301b

// Reset values
`define CDMS_RST_RATIO      16'h0333
`define CDMS_RST_STOPA      16'h301b
`define CDMS_RST_STOPB      16'h9800
`define CDMS_RST_STOPC      16'h0700

// Clock rates in kHz
`define CDMS_MCLK_KHZ       200000
`define CDMS_INPUT_KHZ      5000

`endif

// *** hdl/cdms_rate_div.v ***
module cdms_rate_div #(
    parameter DIVW = 6
) (
    input  wire            mclk,
    input  wire            rst_b,
    input  wire [DIVW-1:0] divCount,
    output reg             tick_r
);

    reg [DIVW-1:0] cnt_r;
    wire           wrap;

    // Greater-or-equal so a smaller new ratio never overshoots
    assign wrap = (cnt_r >= divCount - {{(DIVW-1){1'b0}}, 1'b1});

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r  <= {DIVW{1'b0}};
            tick_r <= 1'b0;
        end else if (wrap) begin
            cnt_r  <= {DIVW{1'b0}};
            tick_r <= 1'b1;
        end else begin
            cnt_r  <= cnt_r + {{(DIVW-1){1'b0}}, 1'b1};
            tick_r <= 1'b0;
        end
    end

endmodule // cdms_rate_div

// *** hdl/cdms_top.v ***
// Notes on behaviour
// - Core ratio bits 10:8; 000 is times eight
// - Core, DMA, transfer controller use core clock
// - Peripheral ratio bits 6:4; 001 is times four
// - External bus ratio bits 2:0; 001 times four
// - Stop bit set stops module; clear restarts
// - Register A bit 15 enables all-stop mode
// - All-stop needs enable, all stopped, sleep
// - All-stop also halts bus controller, ports
// - Register A maps DMA, transfer, converters, timers
// - Register B maps pulse generator, serial 4, 3
// - Register C bits 10:8 stop sync serial
// - Register C bits 1:0 stop RAM bank
// - 5 MHz input gives 40/20/20 MHz clocks
`include "cdms_defs.vh"

module cdms_top #(
    parameter DIVW = 6
) (
    input  wire        mclk,
    input  wire        rst_b,
    input  wire [25:0] wb_adr_i,
    input  wire [31:0] wb_dat_i,
    input  wire [3:0]  wb_sel_i,
    input  wire        wb_we_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    output wire [31:0] wb_dat_o,
    output wire        wb_ack_o,
    input  wire        sleepExec,
    input  wire        wakeEvent,
    output wire        coreClkEn,
    output wire        dmaClkEn,
    output wire        xferClkEn,
    output wire        ramBankClkEn,
    output wire        conv1ClkEn,
    output wire        conv0ClkEn,
    output wire        timerHiClkEn,
    output wire        timerLoClkEn,
    output wire        pulseGenClkEn,
    output wire        serial4ClkEn,
    output wire        serial3ClkEn,
    output wire        sync2ClkEn,
    output wire        sync1ClkEn,
    output wire        sync0ClkEn,
    output wire        busCtrlClkEn,
    output wire        ioPortClkEn,
    output wire        allStopMode
);

    // Mode states
    localparam ST_RUN  = 1'b0;
    localparam ST_STOP = 1'b1;

    // Cycles of mclk per domain tick for each ratio
    localparam integer DIV8_I = `CDMS_MCLK_KHZ / (`CDMS_INPUT_KHZ * 8);
    localparam integer DIV4_I = `CDMS_MCLK_KHZ / (`CDMS_INPUT_KHZ * 4);
    localparam integer DIV2_I = `CDMS_MCLK_KHZ / (`CDMS_INPUT_KHZ * 2);
    localparam integer DIV1_I = `CDMS_MCLK_KHZ / `CDMS_INPUT_KHZ;
    localparam [DIVW-1:0] DIV_X8 = DIV8_I[DIVW-1:0];
    localparam [DIVW-1:0] DIV_X4 = DIV4_I[DIVW-1:0];
    localparam [DIVW-1:0] DIV_X2 = DIV2_I[DIVW-1:0];
    localparam [DIVW-1:0] DIV_X1 = DIV1_I[DIVW-1:0];

    // Register file
    reg  [15:0]     ratioCtl_r;
    reg  [15:0]     stopA_r;
    reg  [15:0]     stopB_r;
    reg  [15:0]     stopC_r;
    reg             mode_r;
    reg             mode_nxt;
    reg             ack_r;
    reg  [15:0]     rdData_r;
    reg  [15:0]     rdData_nxt;

    // Bus decode
    wire            busReq;
    wire            wrEn;
    wire [23:0]     wordIdx;
    wire            hitRatio;
    wire            hitStopA;
    wire            hitStopB;
    wire            hitStopC;
    wire            hitStatus;

    // Domain ticks and divisors
    wire [DIVW-1:0] coreDiv;
    wire [DIVW-1:0] periDiv;
    wire [DIVW-1:0] xbusDiv;
    wire            coreTick;
    wire            periTick;
    wire            xbusTick;

    // Stop requests and gate outputs
    wire            ramStop;
    wire            allStopped;
    wire [3:0]      coreStopReq;
    wire [9:0]      periStopReq;
    wire [1:0]      xbusStopReq;
    wire [9:0]      periStopped;
    wire [1:0]      xbusStopped;
    wire [3:0]      coreEn;
    wire [9:0]      periEn;
    wire [1:0]      xbusEn;

    // Byte-lane merge of a write, keeping only described bits
    function [15:0] mergeWr;
        input [15:0] oldVal;
        input [15:0] newVal;
        input [1:0]  sel;
        input [15:0] mask;
        reg   [15:0] merged;
        begin
            merged[7:0]  = sel[0] ? newVal[7:0]  : oldVal[7:0];
            merged[15:8] = sel[1] ? newVal[15:8] : oldVal[15:8];
            mergeWr      = merged & mask;
        end
    endfunction

    // Ratio code to divisor
    function [DIVW-1:0] ratioDiv;
        input [2:0] code;
        begin
            case (code)
                `CDMS_CODE_X8: ratioDiv = DIV_X8;
                `CDMS_CODE_X4: ratioDiv = DIV_X4;
                `CDMS_CODE_X2: ratioDiv = DIV_X2;
                `CDMS_CODE_X1: ratioDiv = DIV_X1;
                default:       ratioDiv = DIV_X1;
            endcase
        end
    endfunction

    // Wishbone decode
    assign busReq    = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wrEn      = busReq & wb_we_i;
    assign wordIdx   = wb_adr_i[25:2];
    assign hitRatio  = (wordIdx == `CDMS_IDX_RATIO);
    assign hitStopA  = (wordIdx == `CDMS_IDX_STOPA);
    assign hitStopB  = (wordIdx == `CDMS_IDX_STOPB);
    assign hitStopC  = (wordIdx == `CDMS_IDX_STOPC);
    assign hitStatus = (wordIdx == `CDMS_IDX_STATUS);

    // Register writes
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ratioCtl_r <= `CDMS_RST_RATIO;
            stopA_r    <= `CDMS_RST_STOPA;
            stopB_r    <= `CDMS_RST_STOPB;
            stopC_r    <= `CDMS_RST_STOPC;
        end else if (wrEn) begin
            if (hitRatio) begin
                ratioCtl_r <= mergeWr(ratioCtl_r, wb_dat_i[15:0], wb_sel_i[1:0],
                                      `CDMS_MASK_RATIO);
            end
            if (hitStopA) begin
                stopA_r <= mergeWr(stopA_r, wb_dat_i[15:0], wb_sel_i[1:0],
                                   `CDMS_MASK_STOPA);
            end
            if (hitStopB) begin
                stopB_r <= mergeWr(stopB_r, wb_dat_i[15:0], wb_sel_i[1:0],
                                   `CDMS_MASK_STOPB);
            end
            if (hitStopC) begin
                stopC_r <= mergeWr(stopC_r, wb_dat_i[15:0], wb_sel_i[1:0],
                                   `CDMS_MASK_STOPC);
            end
        end
    end

    // Read data mux; unmapped reads return zero
    always @* begin
        rdData_nxt = 16'h0000;
        if (hitRatio) begin
            rdData_nxt = ratioCtl_r;
        end
        if (hitStopA) begin
            rdData_nxt = stopA_r;
        end
        if (hitStopB) begin
            rdData_nxt = stopB_r;
        end
        if (hitStopC) begin
            rdData_nxt = stopC_r;
        end
        if (hitStatus) begin
            rdData_nxt = {12'h000, &xbusStopped, &periStopped, allStopped, mode_r};
        end
    end

    // Single-cycle acknowledge, any address
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ack_r    <= 1'b0;
            rdData_r <= 16'h0000;
        end else begin
            ack_r <= busReq;
            if (busReq) begin
                rdData_r <= rdData_nxt;
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = {16'h0000, rdData_r};

    // Every stop-controlled module stopped
    assign allStopped = ((stopA_r & `CDMS_STOPS_A) == `CDMS_STOPS_A)
                      & ((stopB_r & `CDMS_MASK_STOPB) == `CDMS_MASK_STOPB)
                      & ((stopC_r & `CDMS_MASK_STOPC) == `CDMS_MASK_STOPC);

    // All-module-clock-stop mode
    always @* begin
        mode_nxt = mode_r;
        case (mode_r)
            ST_RUN: begin
                if (sleepExec & stopA_r[`CDMS_A_ALLSTOP_EN] & allStopped) begin
                    mode_nxt = ST_STOP;
                end
            end
            ST_STOP: begin
                if (wakeEvent) begin
                    mode_nxt = ST_RUN;
                end
            end
            default: begin
                mode_nxt = ST_RUN;
            end
        endcase
    end

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mode_r <= ST_RUN;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    assign allStopMode = mode_r;

    // Domain divisors from the ratio fields
    assign coreDiv = ratioDiv(ratioCtl_r[`CDMS_CORE_MSB:`CDMS_CORE_LSB]);
    assign periDiv = ratioDiv(ratioCtl_r[`CDMS_PERI_MSB:`CDMS_PERI_LSB]);
    assign xbusDiv = ratioDiv(ratioCtl_r[`CDMS_XBUS_MSB:`CDMS_XBUS_LSB]);

    cdms_rate_div #(
        .DIVW     (DIVW)
    ) u_core_div (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .divCount (coreDiv),
        .tick_r   (coreTick)
    );

    cdms_rate_div #(
        .DIVW     (DIVW)
    ) u_peri_div (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .divCount (periDiv),
        .tick_r   (periTick)
    );

    cdms_rate_div #(
        .DIVW     (DIVW)
    ) u_xbus_div (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .divCount (xbusDiv),
        .tick_r   (xbusTick)
    );

    // RAM bank stops if either half bit is set
    assign ramStop = stopC_r[`CDMS_C_RAM_HI] | stopC_r[`CDMS_C_RAM_LO];

    // Core-clock modules: core, DMA, transfer controller, RAM bank
    assign coreStopReq = {ramStop | mode_r,
                          stopA_r[`CDMS_A_XFER] | mode_r,
                          stopA_r[`CDMS_A_DMA] | mode_r,
                          mode_r};

    // Peripheral-clock modules
    assign periStopReq = {stopA_r[`CDMS_A_CONV1],
                          stopA_r[`CDMS_A_CONV0],
                          stopA_r[`CDMS_A_TMR_HI],
                          stopA_r[`CDMS_A_TMR_LO],
                          stopB_r[`CDMS_B_PULSE_GEN],
                          stopB_r[`CDMS_B_SERIAL4],
                          stopB_r[`CDMS_B_SERIAL3],
                          stopC_r[`CDMS_C_SYNC2],
                          stopC_r[`CDMS_C_SYNC1],
                          stopC_r[`CDMS_C_SYNC0]} | {10{mode_r}};

    // Bus controller and I/O ports halt only in all-stop mode
    assign xbusStopReq = {mode_r, mode_r};

    cdms_clk_gate #(
        .N         (4)
    ) u_core_gate (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .tick      (coreTick),
        .stopReq   (coreStopReq),
        .stopped_r (),
        .clkEn_r   (coreEn)
    );

    cdms_clk_gate #(
        .N         (10)
    ) u_peri_gate (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .tick      (periTick),
        .stopReq   (periStopReq),
        .stopped_r (periStopped),
        .clkEn_r   (periEn)
    );

    cdms_clk_gate #(
        .N         (2)
    ) u_xbus_gate (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .tick      (xbusTick),
        .stopReq   (xbusStopReq),
        .stopped_r (xbusStopped),
        .clkEn_r   (xbusEn)
    );

    // Clock enable outputs
    assign coreClkEn     = coreEn[0];
    assign dmaClkEn      = coreEn[1];
    assign xferClkEn     = coreEn[2];
    assign ramBankClkEn  = coreEn[3];
    assign conv1ClkEn    = periEn[9];
    assign conv0ClkEn    = periEn[8];
    assign timerHiClkEn  = periEn[7];
    assign timerLoClkEn  = periEn[6];
    assign pulseGenClkEn = periEn[5];
    assign serial4ClkEn  = periEn[4];
    assign serial3ClkEn  = periEn[3];
    assign sync2ClkEn    = periEn[2];
    assign sync1ClkEn    = periEn[1];
    assign sync0ClkEn    = periEn[0];
    assign busCtrlClkEn  = xbusEn[1];
    assign ioPortClkEn   = xbusEn[0];

endmodule // cdms_top

// *** verif/cdms_top_assertions.sv ***
module cdms_checker (
    input logic        mclk,
    input logic        rst_b,
    input logic        wb_cyc_i,
    input logic        wb_stb_i,
    input logic        wb_ack_o,
    input logic [31:0] wb_dat_o,
    input logic        sleepExec,
    input logic        wakeEvent,
    input logic        allStopMode,
    input logic        coreClkEn,
    input logic        dmaClkEn,
    input logic        xferClkEn,
    input logic        busCtrlClkEn,
    input logic        ioPortClkEn
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    logic [5:0] stopCnt_r;

    // Cycles spent in all-stop mode
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) stopCnt_r <= 6'h0;
        else if (!allStopMode) stopCnt_r <= 6'h0;
        else if (stopCnt_r != 6'h3f) stopCnt_r <= stopCnt_r + 6'h1;
    end

    sequence sTaken;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence sAnswer;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    a_ack_one_pulse: assert property (sTaken |=> sAnswer) else $error("ack not one pulse");
    a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_dat_high_zero: assert property (wb_dat_o[31:16] == 16'h0)
        else $error("read data upper half set");
    a_dat_stands: assert property (!wb_ack_o |-> $stable(wb_dat_o))
        else $error("read data changed without ack");
    a_stop_entry: assert property ($rose(allStopMode) |-> $past(sleepExec))
        else $error("all-stop entered without sleep");
    a_stop_exit: assert property (allStopMode && wakeEvent |=> !allStopMode)
        else $error("all-stop not left");
    a_stop_hold: assert property (allStopMode && !wakeEvent |=> allStopMode)
        else $error("all-stop dropped");
    a_stop_quiet: assert property (stopCnt_r > 6'd50 |->
        !(coreClkEn || dmaClkEn || xferClkEn || busCtrlClkEn || ioPortClkEn))
        else $error("clock enable in all-stop");
    a_core_single: assert property (coreClkEn |=> !coreClkEn)
        else $error("core enable too long");
    a_dma_on_core: assert property (dmaClkEn |-> coreClkEn)
        else $error("dma enable off core rate");
    a_bus_io_pair: assert property (busCtrlClkEn == ioPortClkEn)
        else $error("bus and port enables differ");
endmodule // cdms_checker

bind cdms_top cdms_checker cdms_checker_i (
    .mclk(mclk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .sleepExec(sleepExec),
    .wakeEvent(wakeEvent), .allStopMode(allStopMode), .coreClkEn(coreClkEn),
    .dmaClkEn(dmaClkEn), .xferClkEn(xferClkEn), .busCtrlClkEn(busCtrlClkEn),
    .ioPortClkEn(ioPortClkEn)
);

// *** verif/tb.sv ***
`include "cdms_defs.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [23:0] RR = `CDMS_IDX_RATIO;
    localparam logic [23:0] RA = `CDMS_IDX_STOPA;
    localparam logic [23:0] RB = `CDMS_IDX_STOPB;
    localparam logic [23:0] RC = `CDMS_IDX_STOPC;
    localparam logic [23:0] RS = `CDMS_IDX_STATUS;
    logic        mclk = 1'b0;
    logic        rst_b = 1'b0;
    logic [25:0] wbAdr = 26'h0;
    logic [31:0] wbDatW = 32'h0;
    logic [3:0]  wbSel = 4'h0;
    logic        wbWe = 1'b0;
    logic        wbCyc = 1'b0;
    logic        wbStb = 1'b0;
    logic        sleepExec = 1'b0;
    logic        wakeEvent = 1'b0;
    wire  [31:0] wbDatR;
    wire         wbAck;
    wire         allStop;
    wire  [15:0] en;
    int          fails = 0;
    int          n_compared = 0;
    int          cnt [16];
    logic [31:0] q;
    logic [23:0] ix [4] = '{RR, RA, RB, RC};
    logic [15:0] rv [4] = '{`CDMS_RST_RATIO, `CDMS_RST_STOPA, `CDMS_RST_STOPB, `CDMS_RST_STOPC};
    logic [15:0] mk [4] = '{`CDMS_MASK_RATIO, `CDMS_MASK_STOPA, `CDMS_MASK_STOPB,
                            `CDMS_MASK_STOPC};
    logic [23:0] stReg [13] = '{RA, RA, RA, RA, RA, RA, RB, RB, RB, RC, RC, RC, RC};
    logic [15:0] stBit [13] = '{16'h2000, 16'h1000, 16'h0010, 16'h0008, 16'h0002, 16'h0001,
        16'h8000, 16'h1000, 16'h0800, 16'h0400, 16'h0200, 16'h0100, 16'h0003};
    int          stEn [13] = '{1, 2, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 3};

    cdms_top #(.DIVW(6)) cdms_top_i (
        .mclk(mclk), .rst_b(rst_b), .wb_adr_i(wbAdr), .wb_dat_i(wbDatW), .wb_sel_i(wbSel),
        .wb_we_i(wbWe), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_dat_o(wbDatR),
        .wb_ack_o(wbAck), .sleepExec(sleepExec), .wakeEvent(wakeEvent),
        .coreClkEn(en[0]), .dmaClkEn(en[1]), .xferClkEn(en[2]), .ramBankClkEn(en[3]),
        .conv1ClkEn(en[4]), .conv0ClkEn(en[5]), .timerHiClkEn(en[6]), .timerLoClkEn(en[7]),
        .pulseGenClkEn(en[8]), .serial4ClkEn(en[9]), .serial3ClkEn(en[10]),
        .sync2ClkEn(en[11]), .sync1ClkEn(en[12]), .sync0ClkEn(en[13]),
        .busCtrlClkEn(en[14]), .ioPortClkEn(en[15]), .allStopMode(allStop)
    );

    initial begin
        forever #2.5 mclk = ~mclk;
    end

    // Pulse counters for every enable
    always @(posedge mclk) begin
        for (int i = 0; i < 16; i++) begin
            if (en[i] === 1'b1) cnt[i]++;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wbx(input logic w, input logic [23:0] a, input logic [15:0] d,
                       input logic [3:0] s);
        @(posedge mclk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= w;
        wbAdr <= {a, 2'b00};
        wbDatW <= {16'h0, d};
        wbSel <= s;
        do begin
            @(posedge mclk);
        end while (wbAck !== 1'b1);
        q = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask

    task automatic wr(input logic [23:0] a, input logic [15:0] d);
        wbx(1'b1, a, d, 4'h3);
    endtask

    task automatic rd(input logic [23:0] a, input logic [15:0] e);
        wbx(1'b0, a, 16'h0, 4'h3);
        chk(q, {16'h0, e});
    endtask

    task automatic win(input int n);
        repeat (n) @(posedge mclk);
        #1 cnt = '{default: 0};
        repeat (n) @(posedge mclk);
    endtask

    task automatic period(input int i, input int e);
        int t = 0;
        repeat (60) @(posedge mclk);
        while (en[i] !== 1'b1 && t < 100) begin
            @(negedge mclk);
            t++;
        end
        t = 0;
        do begin
            @(negedge mclk);
            t++;
        end while (en[i] !== 1'b1 && t < 100);
        chk(t, e);
    endtask

    task automatic pulse(input logic wake);
        @(posedge mclk);
        if (wake) wakeEvent <= 1'b1;
        else sleepExec <= 1'b1;
        @(posedge mclk);
        sleepExec <= 1'b0;
        wakeEvent <= 1'b0;
        @(negedge mclk);
    endtask

    task automatic t_regs;
        for (int k = 0; k < 4; k++) rd(ix[k], rv[k]);
        rd(24'h000010, 16'h0);
        for (int k = 0; k < 4; k++) begin
            wr(ix[k], 16'hffff);
            rd(ix[k], mk[k]);
        end
        wr(24'h000010, 16'hffff);
        rd(24'h000010, 16'h0);
        wbx(1'b1, RR, 16'h0000, 4'h1);
        rd(RR, 16'h0700);
    endtask

    task automatic t_ratio;
        wr(RA, 16'h0);
        wr(RB, 16'h0);
        wr(RC, 16'h0);
        for (int c = 0; c < 4; c++) begin
            wr(RR, 16'(c * 16'h0111));
            period(0, 5 << c);
            period(1, 5 << c);
            period(5, 5 << c);
            period(14, 5 << c);
        end
        wr(RR, 16'h0011);
        period(2, 5);
        period(13, 10);
        period(15, 10);
    endtask

    task automatic t_stops;
        for (int k = 0; k < 13; k++) begin
            wr(stReg[k], stBit[k]);
            win(60);
            chk(cnt[stEn[k]], 0);
            chk(32'(cnt[0] > 0), 1);
            wr(stReg[k], 16'h0);
            win(60);
            chk(32'(cnt[stEn[k]] > 0), 1);
        end
    endtask

    task automatic t_allstop;
        wr(RA, 16'h301b);
        wr(RB, 16'h9800);
        wr(RC, 16'h0703);
        pulse(1'b0);
        chk(allStop, 0);
        wr(RA, 16'hb01b);
        wr(RC, 16'h0603);
        pulse(1'b0);
        chk(allStop, 0);
        wr(RC, 16'h0703);
        pulse(1'b0);
        chk(allStop, 1);
        win(60);
        chk(cnt[0] + cnt[14] + cnt[15], 0);
        rd(RS, 16'h000f);
        pulse(1'b1);
        chk(allStop, 0);
        win(60);
        chk(32'(cnt[14] > 0), 1);
        chk(32'(cnt[0] > 0), 1);
        rd(RS, 16'h0006);
    endtask

    task automatic t_reset;
        pulse(1'b0);
        chk(allStop, 1);
        @(posedge mclk);
        rst_b <= 1'b0;
        @(negedge mclk);
        chk({allStop, en}, 17'h0);
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        rd(RA, `CDMS_RST_STOPA);
        pulse(1'b0);
        chk(allStop, 0);
    endtask

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        t_regs;
        t_ratio;
        t_stops;
        t_allstop;
        t_reset;
        final_report;
    end

    initial begin
        #100000;
        fails++;
        final_report;
    end
endmodule // tb
